// File: cmb_assertions.sv
`timescale 1ns/10ps
module cmb_assertions
    import cmb_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire cmb_byte_type tx_o,
    input wire logic tx_ready_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    chk_b_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("b lost");
    chk_b_once:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("b twice");
    chk_r_hold:
    assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("r lost");
    chk_r_once:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o) else $error("r twice");
    chk_w_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o)
        else $error("no b");
    chk_rd_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:3] s_axi_rvalid_o)
        else $error("no r");
    chk_aw_pulse:
    assert property (s_axi_awready_o |=> !s_axi_awready_o) else $error("aw ready held");
    chk_ar_pulse:
    assert property (s_axi_arready_o |=> !s_axi_arready_o) else $error("ar ready held");
    chk_err_zero:
    assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_ERR |-> s_axi_rdata_o == 32'h0)
        else $error("err data");
    chk_tx_stall:
    assert property (!tx_ready_i ##1 !tx_ready_i |-> !tx_o.valid) else $error("tx in stall");
    cover property (tx_o.valid && tx_o.data == CH_STX);
    cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_ERR);
    cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule
bind cmb_top cmb_assertions cmb_assertions_i (.clk_i, .resetn_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .tx_o, .tx_ready_i);

// File: cmb_partner.sv
`timescale 1ns/10ps
module cmb_partner
    import cmb_pkg::*;
(
    input wire logic clk_i,
    input wire cmb_byte_type tx_i,
    output logic tx_ready_o,
    output cmb_byte_type rx_o
);
    logic [7:0] got[$];
    logic [2:0] phase_q = 3'h0;
    initial
    begin
        tx_ready_o = 1'b0;
        rx_o = '0;
    end
    // Stalls three cycles in eight
    always @(posedge clk_i)
    begin
        phase_q <= phase_q + 3'h1;
        tx_ready_o <= (phase_q < 3'h5);
    end
    always @(negedge clk_i)
    begin
        if (tx_i.valid)
            got.push_back(tx_i.data);
    end
    // Idle line shows inverted last byte
    task automatic send(input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++)
        begin
            rx_o <= '{valid: 1'b1, data: first + 8'(i)};
            @(posedge clk_i);
        end
        rx_o <= '{valid: 1'b0, data: ~(first + 8'(n - 1))};
    endtask
endmodule

// File: cmb_pkg.sv
package cmb_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned CLEAR_MS = 20;
    localparam int unsigned CLEAR_CYC = CLEAR_MS * (CLK_HZ / 1000);
    localparam int unsigned BUF_BYTES = 1024;
    localparam int unsigned IMG_BYTES = 8;
    localparam int unsigned DATA_OFS = 2;
    localparam logic [7:0] RESET_PAT = 8'haa;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ACT = 8'h2b;
    localparam logic [7:0] CH_DEACT = 8'h2d;
    localparam logic [7:0] CH_VER = 8'h76;
    localparam int unsigned CMD_BIT_VER = 0;
    localparam int unsigned CMD_BIT_GATE = 1;
    localparam int unsigned B_CMD_MODE = 0;
    localparam int unsigned B_WAIT_FLAG = 3;
    localparam int unsigned B_RACK = 0;
    localparam int unsigned B_SEND_BUF = 2;
    localparam int unsigned B_COPY_BUF = 3;
    localparam int unsigned B_BLOCK_TG = 0;
    localparam logic [31:0] A_CTRL = 32'h00000000;
    localparam logic [31:0] A_STATUS = 32'h00000004;
    localparam logic [31:0] A_IN0 = 32'h00000008;
    localparam logic [31:0] A_IN1 = 32'h0000000c;
    localparam logic [31:0] A_IRQ_ST = 32'h00000010;
    localparam logic [31:0] A_IRQ_MASK = 32'h00000014;
    localparam logic [31:0] A_OUT0 = 32'h00000018;
    localparam logic [31:0] A_OUT1 = 32'h0000001c;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cmb_byte_type;
endpackage

// File: cmb_top.sv
`timescale 1ns/10ps
module cmb_top
    import cmb_pkg::*;
#(
    parameter int unsigned DEPTH = BUF_BYTES,
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire cmb_byte_type rx_i,
    output cmb_byte_type tx_o,
    input wire logic tx_ready_i,
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int TAIL = IMG_BYTES - DATA_OFS;

    logic [7:0] ctrl_q [4];
    logic [7:0] out_q [IMG_BYTES];
    logic [7:0] in_q [IMG_BYTES];
    logic [7:0] status_q;
    logic [1:0] irq_st_q;
    logic [1:0] irq_mask_q;
    logic out_wr_q;
    logic aw_got_q, w_got_q;
    logic [31:0] aw_q, w_q;
    logic [3:0] ws_q;
    logic [7:0] rx_mem [DEPTH];
    logic [AW:0] rx_cnt_q;
    logic [AW-1:0] rx_rd_q, rx_wr_q;
    logic [7:0] tx_mem [DEPTH];
    logic [AW:0] tx_cnt_q;
    logic [AW-1:0] tx_rd_q, tx_wr_q;
    logic flush_q;
    logic [7:0] dq_q [TAIL+4];
    logic [3:0] dq_n_q;
    logic [3:0] dq_i_q;
    logic rack_prev_q, copy_prev_q, send_prev_q;
    logic [1:0] cmd_bit_prev_q;
    logic [31:0] clr_cnt_q;
    logic block_ev;

    wire rack_tg = ctrl_q[1][B_RACK] ^ rack_prev_q;
    wire copy_tg = ctrl_q[1][B_COPY_BUF] ^ copy_prev_q;
    wire send_tg = ctrl_q[1][B_SEND_BUF] ^ send_prev_q;
    wire cmd_mode = ctrl_q[0][B_CMD_MODE];
    // Command bits act on their edges, not their levels
    wire [1:0] cmd_now = out_q[DATA_OFS][1:0];
    wire [1:0] cmd_rise = cmd_now & ~cmd_bit_prev_q;
    wire cmd_fall = !cmd_now[CMD_BIT_GATE] && cmd_bit_prev_q[CMD_BIT_GATE];
    wire pat = (ctrl_q[0] == RESET_PAT) && (ctrl_q[1] == RESET_PAT)
        && (out_q[0] == RESET_PAT) && (out_q[1] == RESET_PAT);
    wire wipe = clr_cnt_q >= CLEAR_CYCLES;
    wire rx_push = rx_i.valid && (rx_cnt_q < (AW+1)'(DEPTH));
    wire tx_pop = flush_q && (tx_cnt_q != '0) && (dq_n_q == '0) && tx_ready_i;
    wire dq_pop = (dq_n_q != '0) && tx_ready_i;
    wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid_o;

    // Write channel capture, either order
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            ws_q <= '0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OK;
        end
        else
        begin
            s_axi_awready_o <= !aw_got_q && !s_axi_awready_o;
            s_axi_wready_o <= !w_got_q && !s_axi_wready_o;
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_got_q <= 1'b1;
                aw_q <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_got_q <= 1'b1;
                w_q <= s_axi_wdata_i;
                ws_q <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_go)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_q == A_CTRL || aw_q == A_OUT0 || aw_q == A_OUT1
                    || aw_q == A_IRQ_ST || aw_q == A_IRQ_MASK) ? RESP_OK : RESP_ERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Control and output image registers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 4; i++)
                ctrl_q[i] <= '0;
            for (int i = 0; i < IMG_BYTES; i++)
                out_q[i] <= '0;
            irq_mask_q <= '0;
            out_wr_q <= 1'b0;
        end
        else
        begin
            out_wr_q <= 1'b0;
            if (wipe)
            begin
                for (int i = 0; i < 4; i++)
                    ctrl_q[i] <= '0;
            end
            else if (wr_go)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (ws_q[b])
                    begin
                        if (aw_q == A_CTRL)
                            ctrl_q[b] <= w_q[8*b +: 8];
                        if (aw_q == A_OUT0)
                            out_q[b] <= w_q[8*b +: 8];
                        if (aw_q == A_OUT1)
                            out_q[4+b] <= w_q[8*b +: 8];
                    end
                end
                if (aw_q == A_OUT1)
                    out_wr_q <= 1'b1;
                if (aw_q == A_IRQ_MASK && ws_q[0])
                    irq_mask_q <= w_q[1:0];
            end
        end
    end

    // Reset pattern hold timer
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            clr_cnt_q <= '0;
        else if (!pat || wipe)
            clr_cnt_q <= '0;
        else
            clr_cnt_q <= clr_cnt_q + 32'h00000001;
    end

    // Toggle edge history
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rack_prev_q <= 1'b0;
            copy_prev_q <= 1'b0;
            send_prev_q <= 1'b0;
            cmd_bit_prev_q <= 2'b00;
        end
        else
        begin
            rack_prev_q <= ctrl_q[1][B_RACK];
            copy_prev_q <= ctrl_q[1][B_COPY_BUF];
            send_prev_q <= ctrl_q[1][B_SEND_BUF];
            cmd_bit_prev_q <= cmd_now;
        end
    end

    // Receive buffer; blocks handed out on read-confirm
    assign block_ev = rack_tg && (rx_cnt_q != '0);
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_cnt_q <= '0;
            rx_rd_q <= '0;
            rx_wr_q <= '0;
            status_q <= '0;
            for (int i = 0; i < IMG_BYTES; i++)
                in_q[i] <= '0;
        end
        else if (wipe)
        begin
            rx_cnt_q <= '0;
            rx_rd_q <= '0;
            rx_wr_q <= '0;
            status_q <= '0;
            for (int i = 0; i < IMG_BYTES; i++)
                in_q[i] <= '0;
        end
        else
        begin
            logic [AW:0] take;
            take = (rx_cnt_q > (AW+1)'(TAIL)) ? (AW+1)'(TAIL) : rx_cnt_q;
            if (rx_push)
            begin
                rx_mem[rx_wr_q] <= rx_i.data;
                rx_wr_q <= rx_wr_q + 1'b1;
            end
            if (block_ev)
            begin
                for (int i = 0; i < TAIL; i++)
                    in_q[DATA_OFS+i] <= (i < take) ? rx_mem[AW'(rx_rd_q + AW'(i))]
                        : 8'h00;
                in_q[1] <= 8'(take);
                in_q[0][B_BLOCK_TG] <= ~in_q[0][B_BLOCK_TG];
                rx_rd_q <= AW'(rx_rd_q + take[AW-1:0]);
            end
            rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (block_ev ? take : '0);
            status_q[B_WAIT_FLAG] <= (rx_cnt_q + (AW+1)'(rx_push)
                - (block_ev ? take : '0)) != '0;
        end
    end

    // Transmit buffer: append on copy toggle when not in command mode, flush on send toggle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_cnt_q <= '0;
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            flush_q <= 1'b0;
        end
        else if (wipe)
        begin
            tx_cnt_q <= '0;
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            flush_q <= 1'b0;
        end
        else
        begin
            logic [AW:0] add;
            add = '0;
            if (copy_tg && !cmd_mode)
            begin
                for (int i = 0; i < TAIL; i++)
                begin
                    if (tx_cnt_q + (AW+1)'(i) < (AW+1)'(DEPTH))
                        tx_mem[AW'(tx_wr_q + AW'(i))] <= out_q[DATA_OFS+i];
                end
                add = ((AW+1)'(DEPTH) - tx_cnt_q > (AW+1)'(TAIL)) ? (AW+1)'(TAIL)
                    : (AW+1)'(DEPTH) - tx_cnt_q;
                tx_wr_q <= AW'(tx_wr_q + add[AW-1:0]);
            end
            if (tx_pop)
                tx_rd_q <= tx_rd_q + 1'b1;
            tx_cnt_q <= tx_cnt_q + add - (AW+1)'(tx_pop);
            if (send_tg)
                flush_q <= 1'b1;
            else if (flush_q && tx_cnt_q == '0)
                flush_q <= 1'b0;
        end
    end

    // Direct telegram and command queue
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dq_n_q <= '0;
            dq_i_q <= '0;
            for (int i = 0; i < TAIL+4; i++)
                dq_q[i] <= '0;
        end
        else if (wipe)
        begin
            dq_n_q <= '0;
            dq_i_q <= '0;
        end
        else if (dq_n_q == '0)
        begin
            dq_i_q <= '0;
            if (cmd_mode && (cmd_rise != '0 || cmd_fall))
            begin
                dq_q[0] <= CH_STX;
                dq_q[1] <= cmd_rise[CMD_BIT_GATE] ? CH_ACT
                    : (cmd_fall ? CH_DEACT : CH_VER);
                dq_q[2] <= CH_CR;
                dq_q[3] <= CH_LF;
                dq_n_q <= 4'd4;
            end
            else if (out_wr_q && !cmd_mode && !copy_tg && !send_tg)
            begin
                for (int i = 0; i < TAIL; i++)
                    dq_q[i] <= out_q[DATA_OFS+i];
                dq_n_q <= 4'(TAIL);
            end
        end
        else if (dq_pop)
        begin
            dq_i_q <= dq_i_q + 4'd1;
            if (dq_i_q + 4'd1 == dq_n_q)
                dq_n_q <= '0;
        end
    end

    // Serial output byte
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tx_o <= '0;
        else if (dq_pop)
            tx_o <= '{valid: 1'b1, data: dq_q[dq_i_q]};
        else if (tx_pop)
            tx_o <= '{valid: 1'b1, data: tx_mem[tx_rd_q]};
        else
            tx_o <= '0;
    end

    // Interrupt status: bit0 block presented, bit1 data waiting rise
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_st_q <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            logic [1:0] clr;
            clr = (wr_go && aw_q == A_IRQ_ST && ws_q[0]) ? w_q[1:0] : 2'b00;
            irq_st_q <= (irq_st_q & ~clr) | {rx_push && rx_cnt_q == '0, block_ev};
            irq_o <= |(irq_st_q & irq_mask_q);
        end
    end

    // Read channel
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OK;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o && !s_axi_arvalid_i ? 1'b1
                : (!s_axi_rvalid_o && !s_axi_arready_o);
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= RESP_OK;
                case (s_axi_araddr_i)
                    A_CTRL: s_axi_rdata_o <= {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
                    A_STATUS: s_axi_rdata_o <= {24'h000000, status_q};
                    A_IN0: s_axi_rdata_o <= {in_q[3], in_q[2], in_q[1], in_q[0]};
                    A_IN1: s_axi_rdata_o <= {in_q[7], in_q[6], in_q[5], in_q[4]};
                    A_IRQ_ST: s_axi_rdata_o <= {30'h00000000, irq_st_q};
                    A_IRQ_MASK: s_axi_rdata_o <= {30'h00000000, irq_mask_q};
                    A_OUT0: s_axi_rdata_o <= {out_q[3], out_q[2], out_q[1], out_q[0]};
                    A_OUT1: s_axi_rdata_o <= {out_q[7], out_q[6], out_q[5], out_q[4]};
                    default:
                    begin
                        s_axi_rdata_o <= '0;
                        s_axi_rresp_o <= RESP_ERR;
                    end
                endcase
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
    import cmb_pkg::*;
    localparam int DEP = 16;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, ctrl = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, txr;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    cmb_byte_type rx, tx;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk_i = ~clk_i;
    cmb_top #(.DEPTH(DEP), .CLEAR_CYCLES(20)) cmb_top_i (.clk_i, .resetn_i,
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_i(rx), .tx_o(tx),
        .tx_ready_i(txr), .irq_o(irq));
    cmb_partner cmb_partner_i (.clk_i, .tx_i(tx), .tx_ready_o(txr), .rx_o(rx));
    task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_i);
        cmp(e, d);
    endtask
    task automatic txchk(input logic [7:0] e[$]);
        int n = 0;
        while (cmb_partner_i.got.size() < e.size() && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (20) @(posedge clk_i);
        cmp(32'(e.size()), 32'(cmb_partner_i.got.size()));
        foreach (e[i])
            if (i < cmb_partner_i.got.size()) cmp({24'h0, e[i]}, {24'h0, cmb_partner_i.got[i]});
        cmb_partner_i.got.delete();
    endtask
    task automatic flip(input int b);
        ctrl[b] = ~ctrl[b];
        wr(A_CTRL, ctrl);
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [7:0] bv(input int i);
        return (i < DEP) ? 8'h30 + 8'(i) : 8'h00;
    endfunction
    task automatic t_regs();
        rchk(A_CTRL, 32'h0);
        rchk(A_STATUS, 32'h0);
        rchk(A_IRQ_MASK, 32'h0);
        rchk(32'h40, 32'h0);
        cmp({30'h0, RESP_ERR}, {30'h0, r});
        wr(32'h44, 32'h1);
        cmp({30'h0, RESP_ERR}, {30'h0, r});
        $display("test regs done");
    endtask
    task automatic t_direct();
        wr(A_OUT0, 32'h41020000);
        wr(A_OUT1, 32'h0a0d4342);
        txchk('{8'h02, 8'h41, 8'h42, 8'h43, 8'h0d, 8'h0a});
        $display("test direct done");
    endtask
    task automatic t_buffer();
        wr(A_OUT0, 32'h2b020000);
        flip(B_COPY_BUF + 8);
        wr(A_OUT0, 32'h0a0d0000);
        flip(B_COPY_BUF + 8);
        txchk('{});
        flip(B_SEND_BUF + 8);
        txchk('{8'h02, 8'h2b, 8'h42, 8'h43, 8'h0d, 8'h0a, 8'h0d, 8'h0a, 8'h42, 8'h43,
            8'h0d, 8'h0a});
        flip(B_SEND_BUF + 8);
        txchk('{});
        $display("test buffer done");
    endtask
    task automatic t_cmd();
        wr(A_OUT0, 32'h0);
        flip(B_CMD_MODE);
        wr(A_OUT0, 32'h00020000);
        txchk('{CH_STX, CH_ACT, CH_CR, CH_LF});
        wr(A_OUT0, 32'h00030000);
        txchk('{CH_STX, CH_VER, CH_CR, CH_LF});
        wr(A_OUT0, 32'h0);
        txchk('{CH_STX, CH_DEACT, CH_CR, CH_LF});
        wr(A_OUT1, 32'h11223344);
        txchk('{});
        flip(B_CMD_MODE);
        $display("test command done");
    endtask
    task automatic t_recv();
        int k;
        int n;
        logic t;
        t = 1'b0;
        cmb_partner_i.send(DEP + 2, 8'h30);
        repeat (4) @(posedge clk_i);
        cmp(32'h0, {31'h0, irq});
        rchk(A_STATUS, 32'h8);
        rchk(A_IN0, 32'h0);
        wr(A_IRQ_MASK, 32'h3);
        cmp(32'h1, {31'h0, irq});
        for (k = 0; k < DEP; k += 6)
        begin
            flip(B_RACK + 8);
            t = ~t;
            n = (DEP - k < 6) ? DEP - k : 6;
            rchk(A_IN0, {bv(k + 1), bv(k), 8'(n), 7'h0, t});
            rchk(A_IN1, {bv(k + 5), bv(k + 4), bv(k + 3), bv(k + 2)});
            rchk(A_STATUS, (k + 6 < DEP) ? 32'h8 : 32'h0);
        end
        flip(B_RACK + 8);
        rchk(A_STATUS, 32'h0);
        wr(A_IRQ_ST, 32'h3);
        rchk(A_IRQ_ST, 32'h0);
        cmp(32'h0, {31'h0, irq});
        $display("test receive done");
    endtask
    task automatic t_wipe();
        cmb_partner_i.send(3, 8'h50);
        rchk(A_STATUS, 32'h8);
        wr(A_OUT0, 32'haaaaaaaa);
        ctrl = 32'h0000aaaa;
        wr(A_CTRL, ctrl);
        repeat (40) @(posedge clk_i);
        ctrl = 32'h0;
        rchk(A_CTRL, 32'h0);
        rchk(A_STATUS, 32'h0);
        rchk(A_IN0, 32'h0);
        $display("test wipe done");
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_regs();
        t_direct();
        t_buffer();
        t_cmd();
        t_recv();
        t_wipe();
        final_report();
    end
endmodule
